// [common/gain_corr_defs.vh]
// Constants for the decimator gain-correction stage.
// Function
// - Every decimated result is multiplied by the coefficient before reaching output.
// - Coefficient is 16-bit unsigned fixed point, gain zero to just below two.
// - Valid-bits setting holds usable coefficient bit count minus one.
// - Setting below 15 shifts the coefficient right by fifteen minus setting.
// - Coefficient bits shifted below bit zero are discarded.
`ifndef GAIN_CORR_DEFS_VH
`define GAIN_CORR_DEFS_VH
`define COEF_OFFSET 4'h0
`define VALID_BITS_OFFSET 4'h4
`define STATUS_OFFSET 4'h8
`define RESULT_OFFSET 4'hC
`define COEF_RESET 16'h8000
`define VALID_BITS_RESET 4'hF
`define VALID_BITS_FULL 4'hF
`define COEF_FRAC_BITS 15
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [design/gain_correction.v]
// Gain-correction stage with AXI4-Lite registers and a two-entry output buffer.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`include "gain_corr_defs.vh"

module gain_correction #(
    parameter RES_W = 20
) (
    input wire CLK_I,
    input wire RST_I,
    input wire [RES_W-1:0] S_DATA_I,
    input wire S_VALID_I,
    output reg S_READY_O,
    output reg [RES_W-1:0] M_DATA_O,
    output reg M_VALID_O,
    input wire M_READY_I,
    input wire [3:0] AWADDR_I,
    input wire AWVALID_I,
    output reg AWREADY_O,
    input wire [31:0] WDATA_I,
    input wire [3:0] WSTRB_I,
    input wire WVALID_I,
    output reg WREADY_O,
    output reg [1:0] BRESP_O,
    output reg BVALID_O,
    input wire BREADY_I,
    input wire [3:0] ARADDR_I,
    input wire ARVALID_I,
    output reg ARREADY_O,
    output reg [31:0] RDATA_O,
    output reg [1:0] RRESP_O,
    output reg RVALID_O,
    input wire RREADY_I
);

    localparam PROD_W = RES_W + 17;

    reg [15:0] coef;
    reg [3:0] valid_bits;
    reg [3:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    reg [RES_W-1:0] buf_data [0:1];
    reg [1:0] count;
    reg wr_ptr;
    reg rd_ptr;
    reg [RES_W-1:0] last_result;
    reg saturated;

    // ---------------------------------------------------------------
    // Coefficient alignment and product
    // ---------------------------------------------------------------
    wire [3:0] shift_amt = `VALID_BITS_FULL - valid_bits;
    wire [15:0] eff_coef = coef >> shift_amt;
    wire [PROD_W-1:0] product = S_DATA_I * eff_coef;
    wire [PROD_W-1:0] scaled = product >> `COEF_FRAC_BITS;
    wire overflow = |scaled[PROD_W-1:RES_W];
    wire [RES_W-1:0] corrected = overflow ? {RES_W{1'b1}} :
        scaled[RES_W-1:0];

    // ---------------------------------------------------------------
    // Two-entry output buffer
    // ---------------------------------------------------------------
    wire push = S_VALID_I && S_READY_O;
    wire pop = M_VALID_O && M_READY_I;
    wire [1:0] next_count = count + {1'b0, push} - {1'b0, pop};
    wire next_rd_ptr = pop ? ~rd_ptr : rd_ptr;

    always @(posedge CLK_I) begin
        if (RST_I) begin
            count <= 2'h0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            S_READY_O <= 1'b0;
            M_VALID_O <= 1'b0;
            M_DATA_O <= {RES_W{1'b0}};
            last_result <= {RES_W{1'b0}};
            saturated <= 1'b0;
        end else begin
            if (push) begin
                buf_data[wr_ptr] <= corrected;
                wr_ptr <= ~wr_ptr;
                last_result <= corrected;
                if (overflow) begin
                    saturated <= 1'b1;
                end
            end
            count <= next_count;
            rd_ptr <= next_rd_ptr;
            S_READY_O <= (next_count != 2'h2);
            M_VALID_O <= (next_count != 2'h0);
            if (next_count == 2'h0) begin
                M_DATA_O <= {RES_W{1'b0}};
            end else if (push && next_rd_ptr == wr_ptr) begin
                // The entry written at this edge is the next one shown, so
                // its stored copy is not ready yet and the new value is used.
                M_DATA_O <= corrected;
            end else begin
                M_DATA_O <= buf_data[next_rd_ptr];
            end
            if (aw_held && w_held && !BVALID_O && aw_addr ==
                    `STATUS_OFFSET && w_data[0]) begin
                saturated <= push && overflow;
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RST_I) begin
            coef <= `COEF_RESET;
            valid_bits <= `VALID_BITS_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            AWREADY_O <= 1'b1;
            WREADY_O <= 1'b1;
            BVALID_O <= 1'b0;
            BRESP_O <= `RESP_OKAY;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                aw_addr <= AWADDR_I;
                aw_held <= 1'b1;
                AWREADY_O <= 1'b0;
            end
            if (WVALID_I && WREADY_O) begin
                w_data <= WDATA_I;
                w_strb <= WSTRB_I;
                w_held <= 1'b1;
                WREADY_O <= 1'b0;
            end
            if (aw_held && w_held && !BVALID_O) begin
                BVALID_O <= 1'b1;
                BRESP_O <= `RESP_OKAY;
                if (aw_addr == `COEF_OFFSET) begin
                    if (w_strb[0]) begin
                        coef[7:0] <= w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        coef[15:8] <= w_data[15:8];
                    end
                end else if (aw_addr == `VALID_BITS_OFFSET) begin
                    if (w_strb[0]) begin
                        valid_bits <= w_data[3:0];
                    end
                end else if (aw_addr == `STATUS_OFFSET) begin
                    BRESP_O <= `RESP_OKAY;
                end else begin
                    BRESP_O <= `RESP_SLVERR;
                end
            end
            if (BVALID_O && BREADY_I) begin
                BVALID_O <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                AWREADY_O <= 1'b1;
                WREADY_O <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RST_I) begin
            ARREADY_O <= 1'b1;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h00000000;
            RRESP_O <= `RESP_OKAY;
        end else begin
            if (ARVALID_I && ARREADY_O) begin
                ARREADY_O <= 1'b0;
                RVALID_O <= 1'b1;
                RRESP_O <= `RESP_OKAY;
                if (ARADDR_I == `COEF_OFFSET) begin
                    RDATA_O <= {16'h0000, coef};
                end else if (ARADDR_I == `VALID_BITS_OFFSET) begin
                    RDATA_O <= {28'h0000000, valid_bits};
                end else if (ARADDR_I == `STATUS_OFFSET) begin
                    RDATA_O <= {28'h0000000, count, S_READY_O, saturated};
                end else if (ARADDR_I == `RESULT_OFFSET) begin
                    RDATA_O <= {{(32-RES_W){1'b0}}, last_result};
                end else begin
                    RDATA_O <= 32'h00000000;
                    RRESP_O <= `RESP_SLVERR;
                end
            end
            if (RVALID_O && RREADY_I) begin
                RVALID_O <= 1'b0;
                ARREADY_O <= 1'b1;
            end
        end
    end

endmodule // gain_correction

// [verif/cic_source.sv]
// Model of the decimation filter that feeds the stage.
module cic_source #(
    parameter int W = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ready_i,
    output logic [W-1:0] data_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [W-1:0] q[$];
    initial begin
        valid_o = 0;
        data_o = 0;
    end
    // Idle data toggles so a stale word never passes for a new one.
    always @(posedge clk_i) begin
        if (!rst_i && valid_o && ready_i) void'(q.pop_front());
        valid_o <= !rst_i && q.size() != 0;
        data_o <= q.size() != 0 ? q[0] : ~data_o;
    end
endmodule  // cic_source

// [verif/gain_correction_asserts.sv]
// Port checks for the gain-correction stage.
module gain_correction_asserts #(
    parameter RES_W = 20
) (
    input logic CLK_I,
    input logic RST_I,
    input logic [RES_W-1:0] S_DATA_I,
    input logic S_VALID_I,
    input logic S_READY_O,
    input logic [RES_W-1:0] M_DATA_O,
    input logic M_VALID_O,
    input logic M_READY_I
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_take; S_VALID_I && S_READY_O |=> M_VALID_O; endproperty
    a_take: assert property (p_take) else $error("no result");
    property p_stay; M_VALID_O && !M_READY_I |=> M_VALID_O; endproperty
    a_stay: assert property (p_stay) else $error("result lost");
    property p_stable;
        M_VALID_O && !M_READY_I |=> $stable(M_DATA_O);
    endproperty
    a_stable: assert property (p_stable) else $error("result moved");
    property p_idle; !M_VALID_O |-> M_DATA_O == 0; endproperty
    a_idle: assert property (p_idle) else $error("idle data");
    property p_zero;
        S_VALID_I && S_READY_O && S_DATA_I == 0 && !M_VALID_O
            |=> M_DATA_O == 0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero gained");
    property p_full;
        M_VALID_O && !M_READY_I && !S_READY_O |=> !S_READY_O;
    endproperty
    a_full: assert property (p_full) else $error("overrun");
    c_stall: cover property (M_VALID_O && !M_READY_I ##1 M_VALID_O);
    c_full: cover property (S_VALID_I && !S_READY_O);
    c_flow: cover property (M_VALID_O && M_READY_I);
endmodule  // gain_correction_asserts
bind gain_correction gain_correction_asserts #(.RES_W(RES_W)) i_chk (.*);

// [verif/testbench.sv]
// Self-checking bench for the gain-correction stage.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK_I, RST_I, S_VALID_I, S_READY_O, M_VALID_O, M_READY_I;
    logic [19:0] S_DATA_I, M_DATA_O;
    logic [3:0] AWADDR_I, ARADDR_I, WSTRB_I;
    logic AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
    logic ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
    logic [31:0] WDATA_I, RDATA_O;
    logic [1:0] BRESP_O, RRESP_O;
    int n_fail = 0;
    int samples_checked = 0;
    gain_correction i_gain_correction (.*);
    cic_source i_cic_source (.clk_i(CLK_I), .rst_i(RST_I),
        .ready_i(S_READY_O), .data_o(S_DATA_I), .valid_o(S_VALID_I));
    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, s, e);
        end
    endtask
    function automatic logic [19:0] gain(input logic [19:0] d,
            input logic [15:0] c, input logic [3:0] v);
        logic [51:0] p;
        p = (d * (c >> (15 - v))) >> 15;
        return p > 20'hFFFFF ? 20'hFFFFF : p[19:0];
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        logic [1:0] r;
        int n = 0;
        AWADDR_I <= a;
        WDATA_I <= d;
        AWVALID_I <= 1;
        WVALID_I <= 1;
        do begin
            @(negedge CLK_I);
            aw = AWREADY_O;
            w = WREADY_O;
            b = BVALID_O;
            r = BRESP_O;
            @(posedge CLK_I);
            if (aw) AWVALID_I <= 0;
            if (w) WVALID_I <= 0;
        end while (!b && n++ < 20);
        chk({r, b}, 3'h1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic ar, r;
        logic [33:0] got;
        int n = 0;
        ARADDR_I <= a;
        ARVALID_I <= 1;
        do begin
            @(negedge CLK_I);
            ar = ARREADY_O;
            r = RVALID_O;
            got = {RRESP_O, RDATA_O};
            @(posedge CLK_I);
            if (ar) ARVALID_I <= 0;
        end while (!r && n++ < 20);
        chk({r, got}, {3'h4, e});
    endtask
    task automatic rx(input logic [19:0] e);
        int n = 0;
        M_READY_I <= 1;
        do @(negedge CLK_I);
        while (M_VALID_O !== 1 && n++ < 20);
        chk({M_VALID_O, M_DATA_O}, {1'b1, e});
        @(posedge CLK_I);
    endtask
    task automatic t_gain(input logic [15:0] c, input logic [3:0] v,
            input logic [19:0] d);
        wr(4'h0, {16'h0, c});
        wr(4'h4, {28'h0, v});
        rd(4'h0, {16'h0, c});
        i_cic_source.q.push_back(d);
        rx(gain(d, c, v));
        rd(4'hC, {12'h0, gain(d, c, v)});
        $display("gain test done");
    endtask
    task automatic t_stall;
        M_READY_I <= 0;
        for (int i = 1; i < 5; i++) i_cic_source.q.push_back(20'(i * 'h1111));
        repeat (8) @(posedge CLK_I);
        @(negedge CLK_I);
        chk({S_READY_O, S_VALID_I}, 2'h1);
        @(posedge CLK_I);
        for (int i = 1; i < 5; i++) rx(gain(20'(i * 'h1111), 16'hFFFF, 4'hF));
        $display("stall test done");
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        CLK_I = 0;
        forever #25 CLK_I = ~CLK_I;
    end
    initial begin
        #100us;
        n_fail++;
        complete_run;
    end
    initial begin
        RST_I = 1;
        {M_READY_I, AWVALID_I, WVALID_I, ARVALID_I} = 0;
        {AWADDR_I, ARADDR_I, WDATA_I} = 0;
        {WSTRB_I, BREADY_I, RREADY_I} = '1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 0;
        @(posedge CLK_I);
        rd(4'h0, 32'h8000);
        rd(4'h4, 32'hF);
        t_gain(16'h8000, 4'hF, 20'h003E8);
        t_gain(16'hC000, 4'hF, 20'h00000);
        t_gain(16'hC000, 4'hF, 20'h003E8);
        t_gain(16'h081F, 4'hB, 20'h10000);
        t_gain(16'h8000, 4'h0, 20'h08000);
        rd(4'h8, 32'h2);
        t_gain(16'hFFFF, 4'hF, 20'hFFFFF);
        rd(4'h8, 32'h3);
        wr(4'h8, 32'h1);
        rd(4'h8, 32'h2);
        t_stall;
        complete_run;
    end
endmodule  // testbench
